// [rtl/suc_dev_end.sv]
// Synthesizer end: serial word receiver, register bank, resync and mux out
`timescale 1ns/1ps
`include "suc_consts.svh"
// Notes on behaviour
// - Lock counter starts from the preset field
// - Check lock every cycle or every 32nd
// - Host writes timing adjust field as 00
// - Host writes prescaler bias field as 11
// - Divider mode 10 enables resync, else 00
// - Second resync divider sets sync interval
// - Reserved-only words carry zeros plus address
// - Window width from bias and precision bits
// - Host sets power-down select; bit6 powers down
// - Mux select chooses test output signal
// - Serial output replays previous written word
// - Readback sends value picked by select field
// - Level bit serves lock and test pins
// - Master reset bit clears all registers
// - Sync bit defers strobe to reference fall
// - Host writes thirteen down to zero first
// - Ratio is integer plus fraction over 2^25
// - Integer 16 bits, fraction 25 bits
// - Sync spacing is first times second divider
// - Realign on second sync after strobe
// - Sync bit clear when power-down is written
module suc_dev_end import suc_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    suc_link_if.dev link,
    input wire logic ref_in,
    input wire logic cmp_pulse,
    input wire logic phase_in_window,
    output logic [15:0] int_word,
    output logic [24:0] fraction_numerator,
    output logic [40:0] divide_ratio,
    output logic [3:0] lock_window_code,
    output logic power_down,
    output logic regulator_keep,
    output logic resync_pulse,
    output logic phase_realign,
    output logic locked
);
    logic [31:0] regs_q [`SUC_NREG];
    logic [31:0] shift_q;
    logic [31:0] hold_q;
    logic [31:0] out_sr_q;
    logic sclk_prev_q;
    logic le_prev_q;
    logic ref_prev_q;
    logic pend_q;
    logic test_q;
    logic sclk_rise;
    logic le_rise;
    logic ref_fall;
    logic commit;
    logic [3:0] waddr;
    logic wipe;
    logic [31:0] rb_val;
    logic [5:0] rb_sel;
    logic [11:0] resync_divider_first;
    logic [11:0] resync_divider_second;
    logic [11:0] c1_q;
    logic [11:0] c2_q;
    logic resync_en;
    logic [1:0] arm_q;
    logic freq_load;
    logic [3:0] mux_sel;
    logic [31:0] r12_next;

    ////////////////////////////////////////////////////////////////////////
    // Link edges; pins are synchronous to pclk so no synchroniser is needed
    assign sclk_rise = link.ser_clk & ~sclk_prev_q;
    assign le_rise = link.load_strobe & ~le_prev_q;
    assign ref_fall = ref_prev_q & ~ref_in;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_prev_q <= 1'b0;
            le_prev_q <= 1'b1;
            ref_prev_q <= 1'b0;
        end else begin
            sclk_prev_q <= link.ser_clk;
            le_prev_q <= link.load_strobe;
            ref_prev_q <= ref_in;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shift_q <= 32'h0;
        end else if (sclk_rise && !link.load_strobe) begin
            shift_q <= {shift_q[30:0], link.ser_data};
        end
    end

    // Word is captured at the strobe so a deferred commit survives new shifts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_q <= 32'h0;
        end else if (le_rise) begin
            hold_q <= shift_q;
        end
    end

    // Deferral relies on a running reference; the host clears the bit if not
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_q <= 1'b0;
        end else if (le_rise) begin
            pend_q <= 1'b1;
        end else if (commit) begin
            pend_q <= 1'b0;
        end
    end

    assign commit = pend_q & (~regs_q[`SUC_R12][`SUC_LESYNC_BIT] | ref_fall);

    ////////////////////////////////////////////////////////////////////////
    // Register bank
    assign waddr = hold_q[`SUC_CTL_HI:`SUC_CTL_LO];
    assign wipe = commit && (waddr == `SUC_R12) && hold_q[`SUC_MRST_BIT];

    genvar gi;
    generate
        for (gi = 0; gi < `SUC_NREG; gi++) begin : g_reg
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    regs_q[gi] <= 32'h0;
                end else if (wipe) begin
                    regs_q[gi] <= 32'h0;
                end else if (commit && (waddr == 4'(gi))) begin
                    regs_q[gi] <= hold_q;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Decoded fields
    assign int_word = regs_q[`SUC_R0][`SUC_INT_HI:`SUC_INT_LO];
    assign fraction_numerator = regs_q[`SUC_R1][`SUC_FRAC_HI:`SUC_FRAC_LO];
    assign divide_ratio = {int_word, fraction_numerator};
    assign lock_window_code = {regs_q[`SUC_R9][`SUC_LDB_HI:`SUC_LDB_LO],
        regs_q[`SUC_R6][`SUC_LDP_HI:`SUC_LDP_LO]};
    assign power_down = regs_q[`SUC_R6][`SUC_PD_BIT];
    assign regulator_keep = regs_q[`SUC_R11][`SUC_PDSEL_BIT];
    assign link.level_sel = regs_q[`SUC_R12][`SUC_LVL_BIT];
    assign link.lock_indicator_pin = locked;

    suc_lock_det i_suc_lock_det (
        .pclk(pclk),
        .presetn(presetn),
        .cmp_pulse(cmp_pulse),
        .in_window(phase_in_window),
        .reload(commit && (waddr == `SUC_R7)),
        .preset(regs_q[`SUC_R7][`SUC_LDCNT_HI:`SUC_LDCNT_LO]),
        .every_cycle(regs_q[`SUC_R7][`SUC_LDRATE_BIT]),
        .locked(locked)
    );

    ////////////////////////////////////////////////////////////////////////
    // Test output: replay of the previous word, readback, or lock
    assign mux_sel = regs_q[`SUC_R12][`SUC_MUX_HI:`SUC_MUX_LO];
    // Replay and readback obey the select that this same commit installs
    assign r12_next = (waddr == `SUC_R12) ? hold_q : regs_q[`SUC_R12];
    assign rb_sel = r12_next[`SUC_RBSEL_HI:`SUC_RBSEL_LO];
    // Readback codes 0..13 return that register; the rest return zero
    assign rb_val = (rb_sel < 6'(`SUC_NREG)) ? regs_q[rb_sel[3:0]] : 32'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_sr_q <= 32'h0;
        end else if (commit) begin
            out_sr_q <= (r12_next[`SUC_MUX_HI:`SUC_MUX_LO] == SUC_MUX_SDO) ?
                hold_q : rb_val;
        end else if (sclk_rise && !link.load_strobe) begin
            out_sr_q <= {out_sr_q[30:0], 1'b0};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            test_q <= 1'b0;
        end else begin
            unique case (mux_sel)
                SUC_MUX_LOCK: test_q <= locked;
                SUC_MUX_SDO, SUC_MUX_RDBK: test_q <= out_sr_q[31];
                default: test_q <= 1'b0;
            endcase
        end
    end
    assign link.test_out = test_q;

    ////////////////////////////////////////////////////////////////////////
    // Phase resync timer: nested counters avoid a 24-bit multiplier
    assign resync_divider_first = regs_q[`SUC_R5][`SUC_RESYNC_DIVIDER_FIRST_HI:`SUC_RESYNC_DIVIDER_FIRST_LO];
    assign resync_divider_second = regs_q[`SUC_R7][`SUC_RESYNC_DIVIDER_SECOND_HI:`SUC_RESYNC_DIVIDER_SECOND_LO];
    assign resync_en = regs_q[`SUC_R7][`SUC_CDM_HI:`SUC_CDM_LO]
        == `SUC_CDM_RESYNC;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            c1_q <= 12'h0;
            c2_q <= 12'h0;
            resync_pulse <= 1'b0;
        end else if (!resync_en) begin
            c1_q <= 12'h0;
            c2_q <= 12'h0;
            resync_pulse <= 1'b0;
        end else begin
            resync_pulse <= 1'b0;
            if (cmp_pulse) begin
                if ({1'b0, c1_q} + 13'h1 >= {1'b0, resync_divider_first}) begin
                    c1_q <= 12'h0;
                    if ({1'b0, c2_q} + 13'h1 >= {1'b0, resync_divider_second}) begin
                        c2_q <= 12'h0;
                        resync_pulse <= 1'b1;
                    end else begin
                        c2_q <= c2_q + 12'h1;
                    end
                end else begin
                    c1_q <= c1_q + 12'h1;
                end
            end
        end
    end

    // A new integer or fraction word arms the count of two sync pulses
    assign freq_load = commit && ((waddr == `SUC_R0) || (waddr == `SUC_R1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            arm_q <= 2'h0;
            phase_realign <= 1'b0;
        end else begin
            phase_realign <= 1'b0;
            if (freq_load) begin
                arm_q <= `SUC_ARM_TWO;
            end else if (resync_pulse && (arm_q == `SUC_ARM_TWO)) begin
                arm_q <= `SUC_ARM_ONE;
            end else if (resync_pulse && (arm_q == `SUC_ARM_ONE)) begin
                arm_q <= 2'h0;
                phase_realign <= 1'b1;
            end
        end
    end
endmodule : suc_dev_end

// [rtl/suc_consts.svh]
// Constants for the synthesizer upper configuration link and its two ends
`ifndef SUC_CONSTS_SVH
`define SUC_CONSTS_SVH
`define SUC_NREG 14
`define SUC_BITS_LAST 5'h1f
// Register numbers carried in the control field
`define SUC_R0 4'h0
`define SUC_R1 4'h1
`define SUC_R5 4'h5
`define SUC_R6 4'h6
`define SUC_R7 4'h7
`define SUC_R8 4'h8
`define SUC_R9 4'h9
`define SUC_R10 4'ha
`define SUC_R11 4'hb
`define SUC_R12 4'hc
`define SUC_R13 4'hd
// Field positions
`define SUC_CTL_HI 3
`define SUC_CTL_LO 0
`define SUC_INT_HI 19
`define SUC_INT_LO 4
`define SUC_FRAC_HI 28
`define SUC_FRAC_LO 4
`define SUC_RESYNC_DIVIDER_FIRST_HI 15
`define SUC_RESYNC_DIVIDER_FIRST_LO 4
`define SUC_PD_BIT 6
`define SUC_LDP_HI 9
`define SUC_LDP_LO 8
`define SUC_LDCNT_HI 31
`define SUC_LDCNT_LO 27
`define SUC_LDRATE_BIT 26
`define SUC_PSB_HI 25
`define SUC_PSB_LO 24
`define SUC_NDLY_HI 23
`define SUC_NDLY_LO 22
`define SUC_CDM_HI 19
`define SUC_CDM_LO 18
`define SUC_RESYNC_DIVIDER_SECOND_HI 17
`define SUC_RESYNC_DIVIDER_SECOND_LO 6
`define SUC_LDB_HI 31
`define SUC_LDB_LO 30
`define SUC_PDSEL_BIT 31
`define SUC_MUX_HI 31
`define SUC_MUX_LO 28
`define SUC_LVL_BIT 27
`define SUC_MRST_BIT 22
`define SUC_LESYNC_BIT 20
`define SUC_RBSEL_HI 19
`define SUC_RBSEL_LO 14
// Field values
`define SUC_CDM_RESYNC 2'h2
`define SUC_CDM_OFF 2'h0
`define SUC_PSB_VAL 2'h3
`define SUC_NDLY_VAL 2'h0
`define SUC_LD_SLOW 5'h1f
`define SUC_ARM_TWO 2'h2
`define SUC_ARM_ONE 2'h1
// Host register map (byte addresses)
`define SUC_A_SHD_TOP 8'h34
`define SUC_A_CTRL 8'h40
`define SUC_A_STAT 8'h44
`define SUC_A_RDBK 8'h48
`define SUC_CTRL_SEND 0
`define SUC_CTRL_INIT 1
`define SUC_CTRL_IDX_HI 7
`define SUC_CTRL_IDX_LO 4
`define SUC_STAT_ERR 1
// Last divider count of the serial clock half period, 4 pclk cycles (40 MHz / 8 = 5 MHz)
`define SUC_SCLK_HALF 3'h3
`endif

// [rtl/suc_pkg.sv]
// Types shared by both ends of the synthesizer configuration link
package suc_pkg;
    typedef enum logic [3:0] {
        SUC_MUX_LOW = 4'h0,
        SUC_MUX_LOCK = 4'h1,
        SUC_MUX_SDO = 4'h2,
        SUC_MUX_RDBK = 4'h3
    } suc_mux_t;
    typedef enum logic [2:0] {
        SUC_H_IDLE = 3'h0,
        SUC_H_LOAD = 3'h1,
        SUC_H_LOW = 3'h2,
        SUC_H_HIGH = 3'h3,
        SUC_H_STRB = 3'h4
    } suc_host_st_t;
endpackage : suc_pkg

// [rtl/suc_link_if.sv]
// Three-wire programming link plus the three return signals
`timescale 1ns/1ps
interface suc_link_if;
    logic ser_clk;
    logic ser_data;
    logic load_strobe;
    logic test_out;
    logic lock_indicator_pin;
    logic level_sel;
    modport host (
        output ser_clk, ser_data, load_strobe,
        input test_out, lock_indicator_pin, level_sel
    );
    modport dev (
        input ser_clk, ser_data, load_strobe,
        output test_out, lock_indicator_pin, level_sel
    );
endinterface : suc_link_if

// [rtl/suc_lock_det.sv]
// Digital lock detector counter with preset and check-rate select
`timescale 1ns/1ps
`include "suc_consts.svh"
module suc_lock_det import suc_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic cmp_pulse,
    input wire logic in_window,
    input wire logic reload,
    input wire logic [4:0] preset,
    input wire logic every_cycle,
    output logic locked
);
    logic [4:0] div_q;
    logic [4:0] cnt_q;
    logic check;

    assign check = cmp_pulse & (every_cycle | (div_q == `SUC_LD_SLOW));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= 5'h0;
        end else if (cmp_pulse) begin
            div_q <= div_q + 5'h1;
        end
    end

    // A miss restarts the count from the preset, so the preset sets lock time
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 5'h0;
            locked <= 1'b0;
        end else if (reload || (check && !in_window)) begin
            cnt_q <= preset;
            locked <= 1'b0;
        end else if (check) begin
            if (cnt_q == `SUC_BITS_LAST) begin
                locked <= 1'b1;
            end else begin
                cnt_q <= cnt_q + 5'h1;
            end
        end
    end
endmodule : suc_lock_det

// [rtl/suc_host_end.sv]
// Controller end: APB register block driving the three-wire link
`timescale 1ns/1ps
`include "suc_consts.svh"
module suc_host_end import suc_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    suc_link_if.host link
);
    logic [31:0] shd_q [`SUC_NREG];
    suc_host_st_t st_q;
    logic [31:0] sr_q;
    logic [31:0] rd_q;
    logic [4:0] bits_q;
    logic [3:0] idx_q;
    logic seq_q;
    logic err_q;
    logic dev_sync_q;
    logic [2:0] div_q;
    logic tick;
    logic wr;
    logic busy;
    logic go;
    logic [31:0] word;

    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign wr = psel & penable & pwrite;
    assign busy = (st_q != SUC_H_IDLE);
    assign go = wr && (paddr == `SUC_A_CTRL) && (pwdata[`SUC_CTRL_SEND] ||
        pwdata[`SUC_CTRL_INIT]);
    assign tick = (div_q == `SUC_SCLK_HALF);

    ////////////////////////////////////////////////////////////////////////
    // Shadow words, one per device register
    genvar gi;
    generate
        for (gi = 0; gi < `SUC_NREG; gi++) begin : g_shd
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    shd_q[gi] <= 32'h0;
                end else if (wr && (paddr == 8'(gi * 4))) begin
                    shd_q[gi] <= pwdata;
                end
            end
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (psel && !penable) begin
            if (paddr <= `SUC_A_SHD_TOP && paddr[1:0] == 2'h0) begin
                prdata <= shd_q[paddr[5:2]];
            end else if (paddr == `SUC_A_STAT) begin
                prdata <= {29'h0, dev_sync_q, err_q, busy};
            end else if (paddr == `SUC_A_RDBK) begin
                prdata <= rd_q;
            end else begin
                prdata <= 32'h0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Fixed fields are forced so software cannot program illegal values
    always_comb begin
        word = {shd_q[idx_q][31:4], idx_q};
        unique case (idx_q)
            `SUC_R7: begin
                word[`SUC_NDLY_HI:`SUC_NDLY_LO] = `SUC_NDLY_VAL;
                word[`SUC_PSB_HI:`SUC_PSB_LO] = `SUC_PSB_VAL;
                if (word[`SUC_CDM_HI:`SUC_CDM_LO] != `SUC_CDM_RESYNC) begin
                    word[`SUC_CDM_HI:`SUC_CDM_LO] = `SUC_CDM_OFF;
                end
            end
            `SUC_R8, `SUC_R10, `SUC_R13: word = {28'h0, idx_q};
            `SUC_R11: word[`SUC_PDSEL_BIT] = 1'b1;
            `SUC_R12: begin
                if (seq_q) begin
                    word[`SUC_LESYNC_BIT] = 1'b0;
                end
            end
            default: word = {shd_q[idx_q][31:4], idx_q};
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= 3'h0;
        end else if (st_q == SUC_H_IDLE || st_q == SUC_H_LOAD || tick) begin
            div_q <= 3'h0;
        end else begin
            div_q <= div_q + 3'h1;
        end
    end

    // A power-down word while the device defers its strobe is refused
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_q <= 1'b0;
        end else if ((go && busy) || (st_q == SUC_H_LOAD && idx_q == `SUC_R6
            && dev_sync_q)) begin
            err_q <= 1'b1;
        end else if (wr && paddr == `SUC_A_STAT && pwdata[`SUC_STAT_ERR]) begin
            err_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Serial sequencer: data changes on the falling edge, strobe low in word
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= SUC_H_IDLE;
            sr_q <= 32'h0;
            rd_q <= 32'h0;
            bits_q <= 5'h0;
            idx_q <= 4'h0;
            seq_q <= 1'b0;
            dev_sync_q <= 1'b0;
            link.ser_clk <= 1'b0;
            link.ser_data <= 1'b0;
            link.load_strobe <= 1'b1;
        end else begin
            unique case (st_q)
                SUC_H_IDLE: begin
                    if (go) begin
                        seq_q <= pwdata[`SUC_CTRL_INIT];
                        idx_q <= pwdata[`SUC_CTRL_INIT] ? `SUC_R13 :
                            pwdata[`SUC_CTRL_IDX_HI:`SUC_CTRL_IDX_LO];
                        st_q <= SUC_H_LOAD;
                    end
                end
                SUC_H_LOAD: begin
                    if (idx_q == `SUC_R6 && dev_sync_q) begin
                        st_q <= SUC_H_IDLE;
                        seq_q <= 1'b0;
                    end else begin
                        if (idx_q == `SUC_R12) begin
                            dev_sync_q <= word[`SUC_LESYNC_BIT];
                        end
                        sr_q <= word;
                        link.ser_data <= word[31];
                        link.load_strobe <= 1'b0;
                        bits_q <= 5'h0;
                        st_q <= SUC_H_LOW;
                    end
                end
                SUC_H_LOW: begin
                    if (tick) begin
                        link.ser_clk <= 1'b1;
                        rd_q <= {rd_q[30:0], link.test_out};
                        st_q <= SUC_H_HIGH;
                    end
                end
                SUC_H_HIGH: begin
                    if (tick) begin
                        link.ser_clk <= 1'b0;
                        if (bits_q == `SUC_BITS_LAST) begin
                            link.load_strobe <= 1'b1;
                            st_q <= SUC_H_STRB;
                        end else begin
                            bits_q <= bits_q + 5'h1;
                            sr_q <= {sr_q[30:0], 1'b0};
                            link.ser_data <= sr_q[30];
                            st_q <= SUC_H_LOW;
                        end
                    end
                end
                SUC_H_STRB: begin
                    if (tick) begin
                        if (seq_q && idx_q != `SUC_R0) begin
                            idx_q <= idx_q - 4'h1;
                            st_q <= SUC_H_LOAD;
                        end else begin
                            seq_q <= 1'b0;
                            st_q <= SUC_H_IDLE;
                        end
                    end
                end
                default: st_q <= SUC_H_IDLE;
            endcase
        end
    end
endmodule : suc_host_end

// [sim/suc_asserts.sv]
// Link framing checks between the two ends of the configuration link
`timescale 1ns/1ps
module suc_asserts (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ser_clk,
    input wire logic ser_data,
    input wire logic load_strobe
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////////////
    // Rising serial clock edges seen in the current frame
    logic [5:0] bits_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) bits_q <= 6'h0;
        else if (load_strobe) bits_q <= 6'h0;
        else if ($rose(ser_clk)) bits_q <= bits_q + 6'h1;
    end
    ////////////////////////////////////////////////////////////////////////
    sequence s_open; $fell(load_strobe); endsequence
    sequence s_high4; ser_clk [*4]; endsequence
    property p_idle; load_strobe |-> !ser_clk; endproperty
    property p_high; $rose(ser_clk) |-> s_high4 ##1 !ser_clk; endproperty
    property p_low; $fell(ser_clk) && !load_strobe |-> !ser_clk [*4];
    endproperty
    property p_first; s_open |-> !ser_clk [*4] ##1 ser_clk; endproperty
    property p_hold; ser_clk |-> $stable(ser_data); endproperty
    property p_gap; $rose(load_strobe) |-> load_strobe [*4]; endproperty
    property p_len; s_open |-> !load_strobe [*8]; endproperty
    property p_bits; $rose(load_strobe) |-> bits_q == 6'h20; endproperty
    a_idle: assert property (p_idle)
        else $error("serial clock high outside a frame");
    a_high: assert property (p_high)
        else $error("serial clock high phase not four cycles");
    a_low: assert property (p_low)
        else $error("serial clock low phase not four cycles");
    a_first: assert property (p_first)
        else $error("first serial clock rise misplaced");
    a_hold: assert property (p_hold)
        else $error("serial data moved while clock high");
    a_gap: assert property (p_gap)
        else $error("strobe high gap too short");
    a_len: assert property (p_len)
        else $error("frame too short");
    a_bits: assert property (p_bits)
        else $error("frame did not carry 32 bits");
endmodule : suc_asserts

// [sim/synth_upper_config_registers_test.sv]
// Both link ends joined, driven over APB with checked device outputs
`timescale 1ns/1ps
module synth_upper_config_registers_test import suc_pkg::*; ;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic ref_in = 0, cmp_pulse = 0, phase_in_window = 1;
    logic [7:0] paddr = 8'h0;
    logic [31:0] pwdata = 32'h0, seed = 32'h26, rd, w0, w1, s0;
    logic [31:0] prdata;
    logic pready, pslverr, power_down, regulator_keep, locked;
    logic [15:0] int_word;
    logic [24:0] fraction_numerator;
    logic [40:0] divide_ratio;
    logic [3:0] lock_window_code;
    int err_count = 0, cmp_count = 0;
    logic resync_pulse, phase_realign, cmp_en = 1;
    int ncmp = 0, gap = 0, nsync = 0, nreal = 0, n0 = 0, r0 = 0;
    always #12.5 pclk = ~pclk;
    suc_link_if link ();
    suc_host_end i_suc_host_end (.pclk, .presetn, .paddr, .psel, .penable,
        .pwrite, .pwdata, .prdata, .pready, .pslverr, .link);
    suc_dev_end i_suc_dev_end (.pclk, .presetn, .link, .ref_in, .cmp_pulse,
        .phase_in_window, .int_word, .fraction_numerator, .divide_ratio,
        .lock_window_code, .power_down, .regulator_keep, .resync_pulse,
        .phase_realign, .locked);
    suc_asserts i_suc_asserts (.pclk, .presetn, .ser_clk(link.ser_clk),
        .ser_data(link.ser_data), .load_strobe(link.load_strobe));
    ////////////////////////////////////////////////////////////////////////
    function logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    // Comparison pulses are random but never back to back
    always @(posedge pclk) begin
        cmp_pulse <= cmp_en && !cmp_pulse && xs() > 32'h7fffffff;
        ref_in <= ~ref_in;
    end
    // Comparison pulses between sync pulses, and sync and realign counts
    always @(posedge pclk) begin
        if (resync_pulse) begin
            gap = ncmp;
            ncmp = 0;
            nsync++;
        end
        if (cmp_pulse) ncmp++;
        if (phase_realign) nreal++;
    end
    task chk(input logic [63:0] g, input logic [63:0] e);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task poll();
        do apb(1'b0, 8'h44, 32'h0); while (rd[0] !== 1'b0);
    endtask : poll
    task send(input int i, input logic [31:0] d);
        apb(1'b1, 8'(4 * i), d);
        apb(1'b1, 8'h40, {24'h0, 4'(i), 4'h1});
        poll();
    endtask : send
    task wl(input logic v);
        for (int k = 0; k < 400 && locked !== v; k++) @(posedge pclk);
        chk(locked, v);
    endtask : wl
    task conclude();
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : conclude
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        s0 = xs();
        w1 = xs();
        send(0, s0);
        send(1, w1);
        chk(int_word, s0[19:4]);
        chk(fraction_numerator, w1[28:4]);
        chk(divide_ratio, {s0[19:4], w1[28:4]});
        w0 = {SUC_MUX_SDO, 1'b1, 7'h0, w1[19:4], 4'hc};
        send(12, w0);
        chk(link.level_sel, 1'b1);
        send(0, s0);
        apb(1'b0, 8'h48, 32'h0);
        chk(rd, w0);
        w1 = xs();
        send(7, {w1[31:27], 1'b1, 2'h3, 6'h0, w1[17:6], 6'h7});
        wl(1'b1);
        chk(link.lock_indicator_pin, 1'b1);
        send(12, 32'h1000000c);
        send(11, 32'hb);
        apb(1'b0, 8'h48, 32'h0);
        chk(rd, 32'hffffffff);
        send(12, 32'h3002c00c);
        send(9, {w1[31:30], 26'h0, 4'h9});
        apb(1'b0, 8'h48, 32'h0);
        chk(rd, 32'h8000000b);
        phase_in_window <= 1'b0;
        wl(1'b0);
        phase_in_window <= 1'b1;
        chk(regulator_keep, 1'b1);
        send(6, {22'h0, w1[9:8], 8'h46});
        chk(power_down, 1'b1);
        chk(lock_window_code, {w1[31:30], w1[9:8]});
        apb(1'b1, 8'h4c, 32'hffffffff);
        apb(1'b0, 8'h4c, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, 8'h40, 32'h2);
        poll();
        chk(int_word, s0[19:4]);
        send(12, 32'h40000c);
        chk(divide_ratio, 41'h0);
        chk(power_down, 1'b0);
        send(12, 32'h10000c);
        send(0, w1);
        chk(int_word, w1[19:4]);
        send(6, 32'h46);
        apb(1'b0, 8'h44, 32'h0);
        chk(rd[2:1], 2'h3);
        chk(power_down, 1'b0);
        // Resync with first divider 4 and second 5; pulses paused over load
        send(5, {16'h0, 12'h4, 4'h5});
        send(7, {5'h0, 1'b1, 2'h3, 4'h0, 2'h2, 12'h5, 6'h7});
        cmp_en <= 1'b0;
        send(0, s0);
        n0 = nsync;
        r0 = nreal;
        cmp_en <= 1'b1;
        for (int j = 1; j <= 3; j++) begin
            for (int k = 0; k < 400 && nsync < n0 + j; k++) @(posedge pclk);
            repeat (2) @(posedge pclk);
            chk(nreal - r0, j > 1);
        end
        chk(gap, 4 * 5);
        conclude();
    end
    initial begin
        #1000000;
        err_count++;
        conclude();
    end
endmodule : synth_upper_config_registers_test
